// >>> inc/incr_map.svh
`ifndef INCR_MAP_SVH
`define INCR_MAP_SVH
// opcode patterns, top six bits of the 12-bit word
`define INC_PLAIN_PAT 6'h0A
`define INC_SKIP_PAT 6'h0F
`define OPC_MSB 11
`define OPC_LSB 6
`define DEST_BIT 5
`define FIDX_MSB 4
`define ZERO_BYTE 8'h00
`define ONE_BYTE 8'h01
`define FILE_ADDR_RST 5'h00
`define DATA_RST 8'h00
`endif

// >>> inc/incr_pkg.sv
package incr_pkg;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_INC = 2'b01,
        OP_INC_SKIP = 2'b10
    } inc_op_t;
    typedef struct packed {
        logic we;
        logic [4:0] addr;
        logic [7:0] data;
    } file_wr_t;
    typedef enum logic {
        ST_RUN = 1'b0,
        ST_SKIP = 1'b1
    } exec_state_t;
endpackage

// >>> hw/incr_adder.sv
`timescale 1ns/100ps
`include "incr_map.svh"
module incr_adder #(
    parameter int WIDTH = 8
) (
    // operand
    input wire logic [WIDTH-1:0] operand,
    // result
    output logic [WIDTH-1:0] sum,
    output logic is_zero
);
    // elaboration-time refusal: a zero-width adder has no result to wrap
    if (WIDTH < 1) begin : g_width_check
        $error("incr_adder needs a width of at least one bit");
    end
    // carry out is dropped on purpose so 0xFF wraps to 0x00
    assign sum = WIDTH'(operand + WIDTH'(1));
    assign is_zero = (sum == '0);
endmodule

// >>> hw/increment_file_instructions.sv
`timescale 1ns/100ps
`include "incr_map.svh"
// How it works
// - plain increment adds one to the indexed file register and sets zero flag
// - destination bit zero sends the result to the working register only
// - destination bit one writes the result back to the same file register
// - increment-and-skip stores the result but leaves every status flag unchanged
// - zero result on skip form flushes the prefetched word, running a no-op instead
// - one word each; plain takes one cycle, skip form one or two
module increment_file_instructions (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // fetched instruction
    input wire logic [11:0] instr,
    input wire logic instr_valid,
    // file register read port
    output logic [4:0] file_rd_addr,
    input wire logic [7:0] file_rd_data,
    // file register write port
    output incr_pkg::file_wr_t file_wr,
    // working register
    output logic w_we,
    output logic [7:0] w_data,
    // zero flag
    output logic zero_we,
    output logic zero_val,
    // pipeline control
    output logic flush,
    output logic busy
);
    import incr_pkg::*;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic inc_op_t decode_op(input logic [11:0] w);
        if (w[`OPC_MSB:`OPC_LSB] == `INC_PLAIN_PAT) begin
            return OP_INC;
        end
        if (w[`OPC_MSB:`OPC_LSB] == `INC_SKIP_PAT) begin
            return OP_INC_SKIP;
        end
        return OP_NONE;
    endfunction

    typedef struct packed {
        exec_state_t st;
        file_wr_t fw;
        logic w_we;
        logic [7:0] w_data;
        logic zero_we;
        logic zero_val;
        logic flush;
    } state_t;

    state_t cur_ff;
    state_t nxt_cur;
    inc_op_t op;
    logic [7:0] sum;
    logic is_zero;
    logic take;

    // ----------------------------------------
    // datapath
    // ----------------------------------------
    // read address is combinational so the operand arrives in the same cycle
    assign file_rd_addr = instr[`FIDX_MSB:0];
    assign op = decode_op(instr);

    incr_adder #(
        .WIDTH(8)
    ) u_add (
        .operand(file_rd_data),
        .sum(sum),
        .is_zero(is_zero)
    );

    // the discarded word arriving in the skip cycle is never executed
    assign take = instr_valid && (cur_ff.st == ST_RUN);

    always_comb begin
        // pulses fall back each cycle; data fields keep their last value
        nxt_cur = cur_ff;
        nxt_cur.st = ST_RUN;
        nxt_cur.fw.we = 1'b0;
        nxt_cur.w_we = 1'b0;
        nxt_cur.zero_we = 1'b0;
        nxt_cur.flush = 1'b0;
        if (take && op != OP_NONE) begin
            if (instr[`DEST_BIT]) begin
                nxt_cur.fw.we = 1'b1;
                nxt_cur.fw.addr = instr[`FIDX_MSB:0];
                nxt_cur.fw.data = sum;
            end else begin
                nxt_cur.w_we = 1'b1;
                nxt_cur.w_data = sum;
            end
            if (op == OP_INC) begin
                nxt_cur.zero_we = 1'b1;
                nxt_cur.zero_val = is_zero;
            end
            // skip form never touches zero_we
            if (op == OP_INC_SKIP && is_zero) begin
                nxt_cur.flush = 1'b1;
                nxt_cur.st = ST_SKIP;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '{st: ST_RUN,
                        fw: '{we: 1'b0, addr: `FILE_ADDR_RST, data: `DATA_RST},
                        w_we: 1'b0, w_data: `DATA_RST,
                        zero_we: 1'b0, zero_val: 1'b0, flush: 1'b0};
        end else if (clk_en) begin
            cur_ff <= nxt_cur;
        end
    end

    assign file_wr = cur_ff.fw;
    assign w_we = cur_ff.w_we;
    assign w_data = cur_ff.w_data;
    assign zero_we = cur_ff.zero_we;
    assign zero_val = cur_ff.zero_val;
    assign flush = cur_ff.flush;
    assign busy = (cur_ff.st == ST_SKIP);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_plain_zero_flag: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op == OP_INC |=> zero_we && zero_val == (cur_ff.w_we ?
        w_data == `ZERO_BYTE : file_wr.data == `ZERO_BYTE))
        else $error("plain increment zero flag wrong");
    a_dest_working_reg: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op != OP_NONE && !instr[`DEST_BIT]
        |=> w_we && !file_wr.we)
        else $error("working register destination wrong");
    a_dest_file_reg: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op != OP_NONE && instr[`DEST_BIT]
        |=> file_wr.we && !w_we && file_wr.addr == $past(instr[`FIDX_MSB:0]))
        else $error("file register write back wrong");
    a_skip_no_flags: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op == OP_INC_SKIP |=> !zero_we)
        else $error("skip form touched zero flag");
    a_skip_flush: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op == OP_INC_SKIP && file_rd_data == 8'hFF
        |=> flush && busy)
        else $error("skip did not flush");
    a_no_skip_single: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op == OP_INC_SKIP && file_rd_data != 8'hFF
        |=> !flush && !busy)
        else $error("non-skip took two cycles");
    a_skip_two_cycle: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && busy |=> !busy)
        else $error("skip lasted too long");
    a_wrap_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op != OP_NONE && file_rd_data == 8'hFF && instr[`DEST_BIT]
        |=> file_wr.data == `ZERO_BYTE)
        else $error("increment did not wrap");

    // ----------------------------------------
    // checks: results, holds and freeze
    // ----------------------------------------
    // expected sums are rebuilt from the sampled operand, not taken from the adder
    a_w_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op != OP_NONE && !instr[`DEST_BIT]
        |=> w_data == 8'($past(file_rd_data) + `ONE_BYTE))
        else $error("working register result wrong");
    a_file_result: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op != OP_NONE && instr[`DEST_BIT]
        |=> file_wr.data == 8'($past(file_rd_data) + `ONE_BYTE))
        else $error("file register result wrong");
    a_plain_zero_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op == OP_INC |=> zero_val == ($past(file_rd_data) == 8'hFF))
        else $error("plain increment zero value wrong");
    a_skip_zero_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op == OP_INC_SKIP |=> zero_val == $past(zero_val))
        else $error("skip form changed zero value");
    a_skip_result_stored: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op == OP_INC_SKIP |=> w_we || file_wr.we)
        else $error("skip form dropped its result");
    a_plain_single: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op == OP_INC |=> !busy && !flush)
        else $error("plain increment stalled");
    a_busy_cause: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && !busy && !(take && op == OP_INC_SKIP && file_rd_data == 8'hFF)
        |=> !busy)
        else $error("busy without a zero skip");
    // the flushed word still sits on instr during the no-op cycle
    a_ignored_word: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && busy |=> !file_wr.we && !w_we && !zero_we && !flush)
        else $error("word behind skip was executed");
    a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && !take |=> !file_wr.we && !w_we && !zero_we && !flush)
        else $error("pulse without a taken word");
    a_flush_with_busy: assert property (@(posedge sys_clk) disable iff (!rst_b)
        flush |-> busy)
        else $error("flush without no-op cycle");
    a_flush_pulse: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && flush |=> !flush)
        else $error("flush stood too long");
    a_w_we_dest: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op != OP_NONE |=> w_we != file_wr.we)
        else $error("result went to both or neither destination");
    a_other_opcode: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && take && op == OP_NONE |=> !file_wr.we && !w_we && !zero_we && !flush)
        else $error("foreign opcode had an effect");
    // data fields stand until the next write so the core may pick them up late
    a_w_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && !(take && op != OP_NONE && !instr[`DEST_BIT]) |=> $stable(w_data))
        else $error("working register data drifted");
    a_file_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        clk_en && !(take && op != OP_NONE && instr[`DEST_BIT])
        |=> $stable(file_wr.addr) && $stable(file_wr.data))
        else $error("file write data drifted");
    // a stalled core must see its pulses again on the next live edge
    a_frozen_state: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !clk_en |=> $stable(cur_ff))
        else $error("state moved while clock enable low");
endmodule

// >>> verif/increment_file_instructions_bench.sv
`timescale 1ns/100ps
`include "incr_map.svh"
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin failures++; \
    $display("wrong value %s exp %0h got %0h", n, e, a); end end
module increment_file_instructions_bench;
    import incr_pkg::*;
    logic sys_clk = 0, rst_b = 0, clk_en = 1, instr_valid = 0;
    logic [11:0] instr = 12'h000;
    logic [7:0] file_rd_data = 8'h00;
    logic [4:0] file_rd_addr;
    file_wr_t file_wr;
    logic w_we, zero_we, zero_val, flush, busy;
    logic [7:0] w_data;
    int failures = 0, checks_done = 0;
    increment_file_instructions dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .instr(instr), .instr_valid(instr_valid), .file_rd_addr(file_rd_addr),
        .file_rd_data(file_rd_data), .file_wr(file_wr), .w_we(w_we), .w_data(w_data),
        .zero_we(zero_we), .zero_val(zero_val), .flush(flush), .busy(busy));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // drivers: words go in 1 ns after the edge
    // ----------------------------------------
    task automatic issue(input logic [5:0] opc, input logic d, input logic [4:0] f,
            input logic [7:0] v);
        instr = {opc, d, f};
        instr_valid = 1;
        file_rd_data = v;
        #1 `CHK("file_rd_addr", f, file_rd_addr)
        @(posedge sys_clk);
        #1;
    endtask
    task automatic idle;
        instr_valid = 0;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic t_plain_wrap;
        issue(`INC_PLAIN_PAT, 1'b1, 5'h03, 8'hFF);
        `CHK("file_wr", {1'b1, 5'h03, 8'h00}, file_wr)
        `CHK("zero", 2'b11, {zero_we, zero_val})
        `CHK("w_we", 1'b0, w_we)
        `CHK("busy", 1'b0, busy)
        idle();
        $display("plain wrap done");
    endtask
    task automatic t_plain_w;
        issue(`INC_PLAIN_PAT, 1'b0, 5'h1F, 8'h41);
        `CHK("w", 9'h142, {w_we, w_data})
        `CHK("file_wr.we", 1'b0, file_wr.we)
        `CHK("zero", 2'b10, {zero_we, zero_val})
        idle();
        $display("plain to w done");
    endtask
    // zero result: the word behind the skip must be dropped
    task automatic t_skip_zero;
        issue(`INC_SKIP_PAT, 1'b0, 5'h05, 8'hFF);
        `CHK("w", 9'h100, {w_we, w_data})
        `CHK("zero_we", 1'b0, zero_we)
        `CHK("flush busy", 2'b11, {flush, busy})
        issue(`INC_PLAIN_PAT, 1'b1, 5'h09, 8'h20);
        `CHK("dropped", 3'b000, {file_wr.we, w_we, zero_we})
        `CHK("busy", 1'b0, busy)
        idle();
        $display("skip zero done");
    endtask
    task automatic t_skip_nz;
        issue(`INC_SKIP_PAT, 1'b1, 5'h07, 8'h10);
        `CHK("file_wr", {1'b1, 5'h07, 8'h11}, file_wr)
        `CHK("zero_we", 1'b0, zero_we)
        `CHK("flush busy", 2'b00, {flush, busy})
        issue(`INC_PLAIN_PAT, 1'b0, 5'h00, 8'h7F);
        `CHK("w", 9'h180, {w_we, w_data})
        issue(6'h0B, 1'b1, 5'h08, 8'hFF);
        `CHK("foreign", 4'h0, {file_wr.we, w_we, zero_we, flush})
        idle();
        $display("skip no zero done");
    endtask
    task automatic t_freeze;
        clk_en = 0;
        issue(`INC_PLAIN_PAT, 1'b0, 5'h02, 8'h05);
        `CHK("frozen w_we", 1'b0, w_we)
        clk_en = 1;
        issue(`INC_SKIP_PAT, 1'b1, 5'h04, 8'hFF);
        `CHK("file_wr", {1'b1, 5'h04, 8'h00}, file_wr)
        clk_en = 0;
        idle();
        `CHK("held flush busy", 2'b11, {flush, busy})
        clk_en = 1;
        idle();
        `CHK("busy", 1'b0, busy)
        $display("freeze done");
    endtask
    task automatic t_reset_mid;
        issue(`INC_SKIP_PAT, 1'b0, 5'h06, 8'hFF);
        rst_b = 0;
        instr_valid = 0;
        #1 `CHK("reset pulses", 3'b000, {flush, busy, w_we})
        @(posedge sys_clk);
        #1 rst_b = 1;
        issue(`INC_PLAIN_PAT, 1'b0, 5'h01, 8'h00);
        `CHK("w after reset", 9'h101, {w_we, w_data})
        `CHK("zero after reset", 2'b10, {zero_we, zero_val})
        idle();
        $display("mid reset done");
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #(100 * 100);
        failures++;
        end_of_test();
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 rst_b = 1;
        `CHK("reset busy", 1'b0, busy)
        t_plain_wrap();
        t_plain_w();
        t_skip_zero();
        t_skip_nz();
        t_freeze();
        t_reset_mid();
        end_of_test();
    end
endmodule
